// *** inc/rmq_pkg.sv ***
// constants for the message log and interrupt queue block
// assumes a 40 MHz system clock and 16-bit shared RAM words
package rmq_pkg;
	// timing
	localparam int CLK_NS = 25;
	localparam int US_NS = 1000;
	localparam int US_CYCLES = (US_NS + CLK_NS - 1) / CLK_NS;
	// register indices, byte address is four times the index
	localparam logic [4:0] IDX_MASK1 = 5'h00;
	localparam logic [4:0] IDX_CFG = 5'h01;
	localparam logic [4:0] IDX_STKPTR = 5'h03;
	localparam logic [4:0] IDX_TTAG = 5'h05;
	localparam logic [4:0] IDX_STATUS = 5'h06;
	localparam logic [4:0] IDX_CFG6 = 5'h18;
	localparam logic [4:0] IDX_MASK2 = 5'h1D;
	localparam logic [4:0] IDX_QPTR = 5'h1F;
	// reset values
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [15:0] PTR_RST = 16'h0000;
	// config fields
	localparam int CFG_RES_LSB = 0;
	localparam int CFG_EXT = 3;
	localparam int CFG_CLR_SYNC = 4;
	localparam int CFG_LOAD_SYNC = 5;
	localparam int CFG_LSB0_ONLY = 6;
	localparam int CFG_MODE_DESC = 7;
	localparam int CFG6_NO_VALID = 7;
	localparam int CFG6_NO_INVALID = 8;
	// event positions in status and masks
	localparam int EV_EOM = 0;
	localparam int EV_ERR = 1;
	localparam int EV_SA = 2;
	localparam int EV_CB100 = 3;
	localparam int EV_CB50 = 4;
	localparam int EV_RS100 = 5;
	localparam int EV_RS50 = 6;
	localparam int EV_MODE = 7;
	localparam int EV_TXTO = 8;
	localparam int EV_ILL = 9;
	localparam int EV_QROLL = 10;
	localparam int EV_MT50 = 11;
	localparam int EV_MTD50 = 12;
	localparam int EV_NMSG = 13;
	localparam int NM_TTROLL = 0;
	localparam int NM_APAR = 1;
	localparam int NM_RPAR = 2;
	localparam int NM_BIT = 3;
	localparam int NEV = 17;
	// block status word fields
	localparam int BSW_PROG = 15;
	localparam int BSW_DONE = 14;
	localparam int BSW_CHB = 13;
	localparam int BSW_ERR = 12;
	localparam int BSW_ILL = 11;
	// queue geometry
	localparam int QAW = 6;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_BSW = 4'h1, S_TT = 4'h3, S_PTR = 4'h2,
		S_CMD = 4'h6, S_QV = 4'h7, S_QP = 4'h5, S_NV = 4'h4,
		S_NP = 4'hC, S_SOM = 4'h8
	} rmq_state_t;
endpackage

// *** logic/rmq_log_irq.sv ***
// message descriptor logging, interrupt masking and status queue
// assumes an APB master, a same-clock protocol engine and a RAM write port
`timescale 1ns/1ps
`default_nettype none
module rmq_log_irq #(
	parameter int STACK_WORDS = 256
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// apb slave
	input wire logic [6:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// message events from the protocol engine
	output logic msg_rdy,
	input wire logic msg_start,
	input wire logic msg_end,
	input wire logic msg_chan_b,
	input wire logic msg_illegal,
	input wire logic [7:0] msg_err_flags,
	input wire logic [15:0] msg_cmd,
	input wire logic [15:0] msg_data_ptr,
	input wire logic msg_is_mode,
	input wire logic [15:0] msg_mode_data,
	input wire logic msg_sa_irq,
	input wire logic msg_mode_irq,
	input wire logic msg_tx_timeout,
	input wire logic cbuf_wr,
	input wire logic [15:0] cbuf_addr,
	input wire logic [15:0] cbuf_mask,
	input wire logic mt_cmd_half,
	input wire logic mt_data_half,
	input wire logic sync_nodata,
	input wire logic sync_data,
	input wire logic [15:0] sync_word,
	// non-message events
	input wire logic addr_par_err,
	input wire logic ram_par_err,
	input wire logic [15:0] ram_par_addr,
	input wire logic self_test_done,
	input wire logic ext_ttag_clk,
	// shared ram write port
	output logic ram_req,
	output logic [15:0] ram_addr,
	output logic [15:0] ram_wdata,
	input wire logic ram_gnt,
	// interrupt request
	output logic irq
);
	localparam logic [15:0] SMSK = 16'(STACK_WORDS - 1);
	localparam logic [15:0] SHALF = 16'(STACK_WORDS / 2);

	if (STACK_WORDS < 8 || STACK_WORDS > 32768 ||
		(STACK_WORDS & (STACK_WORDS - 1)) != 0) begin : g_chk
		$error("STACK_WORDS must be a power of two from 8 to 32768");
	end

	function automatic logic mapped(input logic [4:0] idx);
		case (idx)
		rmq_pkg::IDX_MASK1, rmq_pkg::IDX_CFG, rmq_pkg::IDX_STKPTR,
		rmq_pkg::IDX_TTAG, rmq_pkg::IDX_STATUS, rmq_pkg::IDX_CFG6,
		rmq_pkg::IDX_MASK2, rmq_pkg::IDX_QPTR: mapped = 1'b1;
		default: mapped = 1'b0;
		endcase
	endfunction

	rmq_pkg::rmq_state_t state_ff, nxt_state;
	logic [15:0] mask1_ff, cfg_ff, cfg6_ff, stk_ff, qptr_ff;
	logic [0:0] mask2_ff;
	logic [rmq_pkg::NEV-1:0] stat_ff, ev_set, mask_all;
	logic [15:0] desc_ff, tt_ff, bsw_ff, w3_ff, cmd_ff, qvec_ff, nvec_ff;
	logic [15:0] npar_ff, par_addr_ff, ttag;
	logic [3:0] npend_ff, nm_raw;
	logic [1:0] cb_acc_ff;
	logic qmsg_ff, ttroll, wr_acc, rd_setup, nm_take, cb50, cb100;
	logic [4:0] idx;
	logic [15:0] soff, snext, cb_off;
	logic [12:0] mev;
	logic tt_load, tt_clr, qwr, qwrap, msg_ok;

	// apb: zero wait states, read data captured in the setup cycle
	assign idx = paddr[6:2];
	assign pready = 1'b1;
	assign wr_acc = psel && penable && pwrite && mapped(idx);
	assign rd_setup = psel && !penable;
	assign pslverr = psel && penable && !mapped(idx);
	assign mask_all = {mask2_ff, mask1_ff};

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			case (idx)
			rmq_pkg::IDX_MASK1: prdata <= {16'h0000, mask1_ff};
			rmq_pkg::IDX_MASK2: prdata <= {31'h00000000, mask2_ff};
			rmq_pkg::IDX_CFG: prdata <= {16'h0000, cfg_ff};
			rmq_pkg::IDX_CFG6: prdata <= {16'h0000, cfg6_ff};
			rmq_pkg::IDX_STKPTR: prdata <= {16'h0000, stk_ff};
			rmq_pkg::IDX_TTAG: prdata <= {16'h0000, ttag};
			rmq_pkg::IDX_STATUS: prdata <= {15'h0000, stat_ff};
			rmq_pkg::IDX_QPTR: prdata <= {16'h0000, qptr_ff};
			default: prdata <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			mask1_ff <= rmq_pkg::MASK_RST;
			mask2_ff <= 1'b0;
			cfg_ff <= rmq_pkg::CFG_RST;
			cfg6_ff <= rmq_pkg::CFG_RST;
		end else if (wr_acc) begin
			if (idx == rmq_pkg::IDX_MASK1)
				mask1_ff <= pwdata[15:0];
			if (idx == rmq_pkg::IDX_MASK2)
				mask2_ff <= pwdata[0:0];
			if (idx == rmq_pkg::IDX_CFG)
				cfg_ff <= pwdata[15:0];
			if (idx == rmq_pkg::IDX_CFG6)
				cfg6_ff <= pwdata[15:0];
		end
	end

	// time tag
	assign tt_clr = sync_nodata && cfg_ff[rmq_pkg::CFG_CLR_SYNC];
	assign tt_load = (wr_acc && idx == rmq_pkg::IDX_TTAG) ||
		(sync_data && cfg_ff[rmq_pkg::CFG_LOAD_SYNC] &&
		!(cfg_ff[rmq_pkg::CFG_LSB0_ONLY] && sync_word[0]));

	rmq_time_tag u_ttag (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.res_sel(cfg_ff[rmq_pkg::CFG_RES_LSB +: 3]),
		.ext_sel(cfg_ff[rmq_pkg::CFG_EXT]),
		.ext_clk_pin(ext_ttag_clk),
		.clr(tt_clr),
		.load(tt_load),
		.load_val(wr_acc ? pwdata[15:0] : sync_word),
		.ttag_ff(ttag),
		.roll_ff(ttroll)
	);

	// circular buffer half and wrap points, latched until the next message start
	assign cb_off = cbuf_addr & cbuf_mask;
	assign cb50 = cbuf_wr && (cb_off == (cbuf_mask >> 1));
	assign cb100 = cbuf_wr && (cb_off == cbuf_mask);
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			cb_acc_ff <= 2'h0;
		else
			cb_acc_ff <= (msg_start && msg_rdy ? 2'h0 : cb_acc_ff) |
				{cb100, cb50};
	end

	// descriptor stack advance, four words per message
	assign soff = desc_ff & SMSK;
	assign snext = (desc_ff & ~SMSK) | ((soff + 16'h0004) & SMSK);
	always_comb begin
		mev = 13'h0000;
		mev[rmq_pkg::EV_EOM] = 1'b1;
		mev[rmq_pkg::EV_ERR] = |msg_err_flags;
		mev[rmq_pkg::EV_SA] = msg_sa_irq;
		mev[rmq_pkg::EV_CB100] = cb_acc_ff[1] | cb100;
		mev[rmq_pkg::EV_CB50] = cb_acc_ff[0] | cb50;
		mev[rmq_pkg::EV_RS100] = (soff + 16'h0004) > SMSK;
		mev[rmq_pkg::EV_RS50] = soff < SHALF &&
			(soff + 16'h0004) >= SHALF;
		mev[rmq_pkg::EV_MODE] = msg_mode_irq;
		mev[rmq_pkg::EV_TXTO] = msg_tx_timeout;
		mev[rmq_pkg::EV_ILL] = msg_illegal;
		mev[rmq_pkg::EV_MT50] = mt_cmd_half;
		mev[rmq_pkg::EV_MTD50] = mt_data_half;
	end
	assign msg_ok = !(|msg_err_flags) && !msg_illegal;

	// non-message sources, kept apart from message causes
	assign nm_raw = {self_test_done, ram_par_err, addr_par_err, ttroll};
	assign qwr = ram_gnt && (state_ff == rmq_pkg::S_QV ||
		state_ff == rmq_pkg::S_QP || state_ff == rmq_pkg::S_NV ||
		state_ff == rmq_pkg::S_NP);
	assign qwrap = qwr && (&qptr_ff[rmq_pkg::QAW-1:0]);

	always_comb begin
		ev_set = '0;
		if (msg_end && msg_rdy)
			ev_set[12:0] = mev;
		ev_set[rmq_pkg::EV_CB100] |= cb100;
		ev_set[rmq_pkg::EV_CB50] |= cb50;
		ev_set[rmq_pkg::EV_MT50] = mt_cmd_half;
		ev_set[rmq_pkg::EV_MTD50] = mt_data_half;
		ev_set[rmq_pkg::EV_QROLL] = qwrap;
		ev_set[rmq_pkg::NEV-1:rmq_pkg::EV_NMSG] = nm_raw;
	end

	// sticky status, write one to clear, a new event wins over the clear
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			stat_ff <= '0;
		else if (wr_acc && idx == rmq_pkg::IDX_STATUS)
			stat_ff <= (stat_ff & ~pwdata[rmq_pkg::NEV-1:0]) | ev_set;
		else
			stat_ff <= stat_ff | ev_set;
	end
	assign irq = |(stat_ff & mask_all);

	// pending non-message entries; an event in the take cycle stays pending
	assign nm_take = state_ff == rmq_pkg::S_IDLE && !msg_start &&
		!msg_end && |npend_ff;
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			npend_ff <= 4'h0;
			par_addr_ff <= 16'h0000;
		end else begin
			npend_ff <= (nm_take ? 4'h0 : npend_ff) |
				(nm_raw & mask_all[rmq_pkg::NEV-1:rmq_pkg::EV_NMSG]);
			if (ram_par_err)
				par_addr_ff <= ram_par_addr;
		end
	end

	// captured entry contents
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			desc_ff <= 16'h0000;
			tt_ff <= 16'h0000;
			bsw_ff <= 16'h0000;
			w3_ff <= 16'h0000;
			cmd_ff <= 16'h0000;
			qvec_ff <= 16'h0000;
			qmsg_ff <= 1'b0;
			nvec_ff <= 16'h0000;
			npar_ff <= 16'h0000;
		end else begin
			if (msg_start && msg_rdy) begin
				desc_ff <= stk_ff;
				tt_ff <= ttag;
				bsw_ff <= 16'h0000;
				bsw_ff[rmq_pkg::BSW_PROG] <= 1'b1;
				bsw_ff[rmq_pkg::BSW_CHB] <= msg_chan_b;
			end
			if (msg_end && msg_rdy) begin
				bsw_ff <= {1'b0, 1'b1, msg_chan_b, |msg_err_flags,
					msg_illegal, 3'h0, msg_err_flags};
				w3_ff <= (msg_is_mode && cfg_ff[rmq_pkg::CFG_MODE_DESC]) ?
					msg_mode_data : msg_data_ptr;
				cmd_ff <= msg_cmd;
				qvec_ff <= {2'h0, mev & mask1_ff[12:0], 1'b1};
				qmsg_ff <= |(mev & mask1_ff[12:0]) &&
					!(msg_ok ? cfg6_ff[rmq_pkg::CFG6_NO_VALID] :
					cfg6_ff[rmq_pkg::CFG6_NO_INVALID]);
			end
			if (nm_take) begin
				nvec_ff <= {11'h000, npend_ff, 1'b0};
				npar_ff <= npend_ff[rmq_pkg::NM_RPAR] ?
					par_addr_ff : 16'h0000;
			end
		end
	end

	// sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
		rmq_pkg::S_IDLE: begin
			if (msg_end)
				nxt_state = rmq_pkg::S_BSW;
			else if (msg_start)
				nxt_state = rmq_pkg::S_SOM;
			else if (nm_take)
				nxt_state = rmq_pkg::S_NV;
		end
		rmq_pkg::S_SOM:
			if (ram_gnt) nxt_state = rmq_pkg::S_IDLE;
		rmq_pkg::S_BSW:
			if (ram_gnt) nxt_state = rmq_pkg::S_TT;
		rmq_pkg::S_TT:
			if (ram_gnt) nxt_state = rmq_pkg::S_PTR;
		rmq_pkg::S_PTR:
			if (ram_gnt) nxt_state = rmq_pkg::S_CMD;
		rmq_pkg::S_CMD:
			if (ram_gnt)
				nxt_state = qmsg_ff ? rmq_pkg::S_QV : rmq_pkg::S_IDLE;
		rmq_pkg::S_QV:
			if (ram_gnt) nxt_state = rmq_pkg::S_QP;
		rmq_pkg::S_NV:
			if (ram_gnt) nxt_state = rmq_pkg::S_NP;
		rmq_pkg::S_QP, rmq_pkg::S_NP:
			if (ram_gnt) nxt_state = rmq_pkg::S_IDLE;
		default: nxt_state = rmq_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			state_ff <= rmq_pkg::S_IDLE;
		else
			state_ff <= nxt_state;
	end
	assign msg_rdy = state_ff == rmq_pkg::S_IDLE;

	// ram write port; descriptor words at desc_ff .. desc_ff+3
	assign ram_req = state_ff != rmq_pkg::S_IDLE;
	always_comb begin
		ram_addr = qptr_ff;
		ram_wdata = 16'h0000;
		case (state_ff)
		rmq_pkg::S_SOM, rmq_pkg::S_BSW: begin
			ram_addr = desc_ff;
			ram_wdata = bsw_ff;
		end
		rmq_pkg::S_TT: begin
			ram_addr = desc_ff + 16'h0001;
			ram_wdata = tt_ff;
		end
		rmq_pkg::S_PTR: begin
			ram_addr = desc_ff + 16'h0002;
			ram_wdata = w3_ff;
		end
		rmq_pkg::S_CMD: begin
			ram_addr = desc_ff + 16'h0003;
			ram_wdata = cmd_ff;
		end
		rmq_pkg::S_QV: ram_wdata = qvec_ff;
		rmq_pkg::S_QP: ram_wdata = desc_ff;
		rmq_pkg::S_NV: ram_wdata = nvec_ff;
		rmq_pkg::S_NP: ram_wdata = npar_ff;
		default: ram_wdata = 16'h0000;
		endcase
	end

	// pointers: a host write overrides the device's own advance
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			stk_ff <= rmq_pkg::PTR_RST;
		else if (wr_acc && idx == rmq_pkg::IDX_STKPTR)
			stk_ff <= pwdata[15:0];
		else if (state_ff == rmq_pkg::S_CMD && ram_gnt)
			stk_ff <= snext;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			qptr_ff <= rmq_pkg::PTR_RST;
		else if (wr_acc && idx == rmq_pkg::IDX_QPTR)
			qptr_ff <= pwdata[15:0];
		else if (qwr)
			qptr_ff <= {qptr_ff[15:rmq_pkg::QAW],
				qptr_ff[rmq_pkg::QAW-1:0] + 6'h01};
	end
endmodule
`default_nettype wire

// *** logic/rmq_time_tag.sv ***
// relative time tag counter with resolution divider and external clock
// assumes the external time tag clock pin is asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module rmq_time_tag (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// control
	input wire logic [2:0] res_sel,
	input wire logic ext_sel,
	input wire logic ext_clk_pin,
	input wire logic clr,
	input wire logic load,
	input wire logic [15:0] load_val,
	// state
	output logic [15:0] ttag_ff,
	output logic roll_ff
);
	logic ext_s1_ff, ext_s2_ff, ext_s3_ff;
	logic [5:0] us_cnt_ff, res_cnt_ff, res_top;
	logic us_tick, res_tick, adv;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ext_s1_ff <= 1'b0;
			ext_s2_ff <= 1'b0;
			ext_s3_ff <= 1'b0;
		end else begin
			ext_s1_ff <= ext_clk_pin;
			ext_s2_ff <= ext_s1_ff;
			ext_s3_ff <= ext_s2_ff;
		end
	end

	assign us_tick = (us_cnt_ff == 6'(rmq_pkg::US_CYCLES - 1));
	always_ff @(posedge sys_clk) begin
		if (!rst_b || us_tick)
			us_cnt_ff <= 6'h00;
		else
			us_cnt_ff <= us_cnt_ff + 6'h01;
	end

	// 2..64 us per count; selections above 5 saturate at 64
	assign res_top = (res_sel > 3'h5) ? 6'h3F :
		6'((7'h02 << res_sel) - 7'h01);
	assign res_tick = us_tick && (res_cnt_ff >= res_top);
	always_ff @(posedge sys_clk) begin
		if (!rst_b || res_tick)
			res_cnt_ff <= 6'h00;
		else if (us_tick)
			res_cnt_ff <= res_cnt_ff + 6'h01;
	end

	assign adv = ext_sel ? (ext_s2_ff && !ext_s3_ff) : res_tick;

	// a load beats a clear, and both beat the count
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			ttag_ff <= 16'h0000;
		else if (load)
			ttag_ff <= load_val;
		else if (clr)
			ttag_ff <= 16'h0000;
		else if (adv)
			ttag_ff <= ttag_ff + 16'h0001;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			roll_ff <= 1'b0;
		else
			roll_ff <= adv && !load && !clr && (ttag_ff == 16'hFFFF);
	end
endmodule
`default_nettype wire

// *** test/rmq_log_irq_checker.sv ***
// port assertions for the message log and interrupt queue block
// assumes one clock domain; bound onto every rmq_log_irq
`timescale 1ns/1ps
`default_nettype none
module rmq_log_irq_checker (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// apb
	input wire logic [6:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// engine
	input wire logic msg_rdy,
	input wire logic msg_end,
	input wire logic msg_chan_b,
	input wire logic msg_illegal,
	input wire logic [7:0] msg_err_flags,
	input wire logic [15:0] msg_cmd,
	// ram and interrupt
	input wire logic ram_req,
	input wire logic [15:0] ram_addr,
	input wire logic [15:0] ram_wdata,
	input wire logic ram_gnt,
	input wire logic irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic [2:0] cnt_ff;
	logic [15:0] d_ff;
	logic [15:0] cmd_ff;
	logic [5:0] qa_ff;
	logic wg;
	assign wg = ram_req && ram_gnt;
	// word number within one message sequence, 0 outside
	always_ff @(posedge sys_clk) begin
		if (!rst_b || (msg_rdy && !msg_end)) begin
			cnt_ff <= 3'h0;
		end else if (msg_rdy) begin
			cnt_ff <= 3'h1;
		end else if (wg && cnt_ff != 3'h0) begin
			cnt_ff <= cnt_ff + 3'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (msg_rdy && msg_end) begin
			cmd_ff <= msg_cmd;
		end
		if (wg && cnt_ff == 3'h1) begin
			d_ff <= ram_addr;
		end
		// vector address kept, grants may stall between the two words
		if (wg && cnt_ff == 3'h5) begin
			qa_ff <= ram_addr[5:0];
		end
	end
	sequence s_qptr_wr;
		psel && penable && pwrite && paddr[6:2] == 5'h1F && msg_rdy;
	endsequence
	sequence s_qptr_rd;
		psel && !penable && !pwrite && paddr[6:2] == 5'h1F && msg_rdy;
	endsequence
	chk_apb_ready: assert property (
		psel && penable |-> pready && (paddr[6:2] != 5'h1F || !pslverr))
		else $error("apb access not answered");
	chk_bad_index: assert property (
		psel && penable && !(paddr[6:2] inside {5'h00, 5'h01, 5'h03,
		5'h05, 5'h06, 5'h18, 5'h1D, 5'h1F}) |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_qptr_back: assert property (
		s_qptr_wr ##2 s_qptr_rd |=> prdata[15:0] == $past(pwdata[15:0], 3))
		else $error("queue pointer readback differs");
	chk_reset_idle: assert property (
		$rose(rst_b) |-> msg_rdy && !ram_req && !irq)
		else $error("not idle after reset");
	chk_bsw_first: assert property (
		msg_end && msg_rdy |=> ram_req && ram_wdata[14]
		&& ram_wdata[13] == $past(msg_chan_b)
		&& ram_wdata[11] == $past(msg_illegal)
		&& ram_wdata[7:0] == $past(msg_err_flags))
		else $error("block status word wrong");
	chk_req_hold: assert property (
		ram_req && !ram_gnt |=> ram_req && $stable(ram_addr)
		&& $stable(ram_wdata))
		else $error("ram word not held until grant");
	chk_desc_addr: assert property (
		wg && cnt_ff inside {3'h2, 3'h3, 3'h4}
		|-> ram_addr == d_ff + {13'h0, cnt_ff} - 16'h1)
		else $error("descriptor word address wrong");
	chk_cmd_word: assert property (
		wg && cnt_ff == 3'h4 |-> ram_wdata == cmd_ff)
		else $error("command word not logged");
	chk_vec_msg: assert property (
		wg && cnt_ff == 3'h5 |-> ram_wdata[0] && ram_wdata[15:14] == 2'h0)
		else $error("message vector malformed");
	chk_param_ptr: assert property (
		wg && cnt_ff == 3'h6 |-> ram_wdata == d_ff
		&& ram_addr[5:0] == qa_ff + 6'h1)
		else $error("parameter word not status address");
	chk_seq_done: assert property (
		msg_end && msg_rdy |=> !msg_rdy ##[1:100] msg_rdy)
		else $error("message sequence did not finish");
endmodule
bind rmq_log_irq rmq_log_irq_checker u_chk (.sys_clk(sys_clk),
	.rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .msg_rdy(msg_rdy), .msg_end(msg_end),
	.msg_chan_b(msg_chan_b), .msg_illegal(msg_illegal),
	.msg_err_flags(msg_err_flags), .msg_cmd(msg_cmd), .ram_req(ram_req),
	.ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_gnt(ram_gnt),
	.irq(irq));
`default_nettype wire

// *** test/rmq_ram_host.sv ***
// shared ram model on the block's write port
// assumes one word per grant; slow mode grants every fourth cycle
`timescale 1ns/1ps
`default_nettype none
module rmq_ram_host (
	// clock
	input wire logic sys_clk,
	// write port
	input wire logic ram_req,
	input wire logic [15:0] ram_addr,
	input wire logic [15:0] ram_wdata,
	output logic ram_gnt,
	// pacing
	input wire logic slow
);
	logic [15:0] mem [65536];
	logic [1:0] div_ff = 2'h0;
	always_ff @(posedge sys_clk) begin
		div_ff <= div_ff + 2'h1;
	end
	// stalls prove the block holds each word until taken
	assign ram_gnt = ram_req && (!slow || div_ff == 2'h0);
	always @(posedge sys_clk) begin
		if (ram_req && ram_gnt) begin
			mem[ram_addr] <= ram_wdata;
		end
	end
endmodule
`default_nettype wire

// *** test/test_rmq_log_irq.sv ***
// self-checking bench for the message log and interrupt queue block
// assumes the ram model grants every write, slowly on request
`timescale 1ns/1ps
`default_nettype none
module test_rmq_log_irq;
	localparam int SW = 16;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [6:0] paddr = 7'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [9:0] pl = 10'h000;
	logic [5:0] mf = 6'h00;
	logic [7:0] fl = 8'h00;
	logic [15:0] c = 16'h0, p = 16'h0, m = 16'h0, sw = 16'h0;
	logic [15:0] rpa = 16'h0, cba = 16'h0;
	logic ext = 1'b0, slow = 1'b0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, msg_rdy, ram_req, ram_gnt, irq, re;
	logic [15:0] ram_addr, ram_wdata, d, q, tt, cfg, cfg6;
	logic [15:0] mk = 16'hE387;
	logic [31:0] xq[$];
	int n_fail = 0, comparisons = 0, cyc = 0;
	rmq_log_irq #(.STACK_WORDS(SW)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .msg_rdy(msg_rdy), .msg_start(pl[0]),
		.msg_end(pl[1]), .msg_chan_b(mf[0]), .msg_illegal(mf[1]),
		.msg_err_flags(fl), .msg_cmd(c), .msg_data_ptr(p),
		.msg_is_mode(mf[2]), .msg_mode_data(m), .msg_sa_irq(mf[3]),
		.msg_mode_irq(mf[4]), .msg_tx_timeout(mf[5]), .cbuf_wr(pl[2]),
		.cbuf_addr(cba), .cbuf_mask(16'h000F), .mt_cmd_half(pl[3]),
		.mt_data_half(pl[4]), .sync_nodata(pl[5]), .sync_data(pl[6]),
		.sync_word(sw), .addr_par_err(pl[7]), .ram_par_err(pl[8]),
		.ram_par_addr(rpa), .self_test_done(pl[9]), .ext_ttag_clk(ext),
		.ram_req(ram_req), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_gnt(ram_gnt), .irq(irq));
	rmq_ram_host ram (.sys_clk(sys_clk), .ram_req(ram_req),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_gnt(ram_gnt),
		.slow(slow));
	always #12.5 sys_clk = ~sys_clk;
	task automatic end_sim();
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (ram_req === 1'b1 && ram_gnt === 1'b1) begin
			chk({ram_addr, ram_wdata}, xq.size() ? xq.pop_front() : 32'h0);
		end
		if (cyc > 60000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic apb(input logic [4:0] i, input logic w,
		input logic [31:0] dw, output logic [31:0] r, output logic e);
		@(posedge sys_clk);
		paddr <= {i, 2'b00};
		pwrite <= w;
		pwdata <= dw;
		psel <= 1'b1;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] i, input logic [31:0] dw);
		apb(i, 1'b1, dw, rv, re);
	endtask
	task automatic rdc(input logic [4:0] i, input logic [31:0] e,
		input logic [31:0] k);
		apb(i, 1'b0, 32'h0, rv, re);
		chk(rv & k, e);
		chk({31'h0, re}, {31'h0, i == 5'h02});
	endtask
	task automatic pulse(input logic [9:0] b);
		@(posedge sys_clk);
		pl <= b;
		@(posedge sys_clk);
		pl <= 10'h000;
	endtask
	task automatic idle();
		do @(posedge sys_clk); while (msg_rdy !== 1'b1 || xq.size() != 0);
	endtask
	// one queue entry: vector then parameter, pointer wraps in 64
	task automatic qw(input logic [15:0] a, input logic [15:0] b);
		xq.push_back({q, a});
		q = {q[15:6], q[5:0] + 6'h1};
		xq.push_back({q, b});
		q = {q[15:6], q[5:0] + 6'h1};
	endtask
	task automatic msg(input logic [7:0] f8, input logic [5:0] f,
		input logic st);
		logic [15:0] lc, lp, lm;
		logic [9:0] ev;
		lc = 16'($urandom);
		lp = 16'($urandom);
		lm = 16'($urandom);
		ev = {f[1], f[5], f[4], 4'h0, f[3], |f8, 1'b1};
		idle();
		mf <= f;
		xq.push_back({d, 16'h8000 | {2'h0, f[0], 13'h0}});
		pulse(10'h001);
		idle();
		c <= lc;
		p <= lp;
		m <= lm;
		fl <= f8;
		xq.push_back({d, 16'h4000 | {2'h0, f[0], |f8, f[1], 3'h0, f8}});
		xq.push_back({d + 16'h1, tt});
		xq.push_back({d + 16'h2, (cfg[7] && f[2]) ? lm : lp});
		xq.push_back({d + 16'h3, lc});
		if (!((f8 != 8'h0 || f[1]) ? cfg6[8] : cfg6[7])) begin
			qw({5'h0, ev & mk[9:0], 1'b1}, d);
		end
		if (st) begin
			qw(16'h0010, 16'h0);
		end
		pulse({st, 7'h0, 2'b10});
		idle();
		// stack area of SW words, so the low four bits wrap
		d = {d[15:4], d[3:0] + 4'h4};
	endtask
	initial begin
		logic [4:0] tab [9];
		logic [15:0] v;
		tab = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h18, 5'h1D, 5'h1F};
		void'($urandom(28753));
		d = 16'h010C;
		q = 16'h0A3C;
		cfg = 16'h0088;
		cfg6 = 16'h0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		foreach (tab[i]) rdc(tab[i], 32'h0, 32'hFFFFFFFF);
		wr(5'h1F, {16'h0, q});
		rdc(5'h1F, {16'h0, q}, 32'hFFFF);
		wr(5'h03, {16'h0, d});
		wr(5'h00, {16'h0, mk});
		wr(5'h1D, 32'h1);
		wr(5'h01, {16'h0, cfg});
		tt = 16'($urandom);
		wr(5'h05, {16'h0, tt});
		for (int i = 0; i < 6; i++) begin
			slow <= i[0];
			msg(i[1] ? 8'($urandom) : 8'h00, 6'($urandom), i == 3);
		end
		rdc(5'h1F, {16'h0, q}, 32'hFFFF);
		rdc(5'h06, 32'h400, 32'h400);
		for (int i = 0; i < 8; i++) begin
			cfg6 = {7'h0, i[2:1], 7'h0};
			wr(5'h18, {16'h0, cfg6});
			msg({7'h0, i[0]}, 6'h00, 1'b0);
		end
		v = 16'($urandom);
		rpa <= v;
		qw(16'h000C, v);
		pulse(10'h180);
		idle();
		qw(16'h0010, 16'h0);
		pulse(10'h200);
		idle();
		wr(5'h05, 32'hFFFE);
		qw(16'h0002, 16'h0);
		repeat (4) begin
			ext <= ~ext;
			repeat (4) @(posedge sys_clk);
		end
		idle();
		rdc(5'h05, 32'h0, 32'hFFFF);
		wr(5'h01, 32'hB8);
		wr(5'h05, 32'h5555);
		pulse(10'h020);
		rdc(5'h05, 32'h0, 32'hFFFF);
		sw <= 16'h1235;
		pulse(10'h040);
		rdc(5'h05, 32'h1235, 32'hFFFF);
		wr(5'h01, 32'hF8);
		sw <= 16'h2223;
		pulse(10'h040);
		rdc(5'h05, 32'h1235, 32'hFFFF);
		sw <= 16'h2222;
		pulse(10'h040);
		rdc(5'h05, 32'h2222, 32'hFFFF);
		chk({31'h0, irq}, 32'h1);
		wr(5'h06, 32'h1FFFF);
		rdc(5'h06, 32'h0, 32'h1FFFF);
		chk({31'h0, irq}, 32'h0);
		wr(5'h00, 32'h0);
		wr(5'h1D, 32'h0);
		pulse(10'h200);
		rdc(5'h06, 32'h10000, 32'h1FFFF);
		chk({31'h0, irq}, 32'h0);
		for (int i = 0; i < 17; i++) begin
			cba <= 16'h0200 | 16'(i[3:0]);
			pulse(10'h004);
		end
		pulse(10'h018);
		rdc(5'h06, 32'h1818, 32'h1818);
		for (int n = 0; n < 8; n++) begin
			wr(5'h01, n);
			apb(5'h05, 1'b0, 32'h0, rv, re);
			v = rv[15:0];
			repeat (2 * rmq_pkg::US_CYCLES * (2 << (n > 5 ? 5 : n)) - 2)
				@(posedge sys_clk);
			apb(5'h05, 1'b0, 32'h0, rv, re);
			chk({16'h0, rv[15:0] - v}, 32'h2);
		end
		end_sim();
	end
endmodule
`default_nettype wire
